// >>> hdl/acs_regs.vh
// Register offsets, field positions, reset values and counts of the conversion sequencer
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// Register offsets on the processor register port
`define ACS_OFF_STATUS 3'h0
`define ACS_OFF_CTL1 3'h1
`define ACS_OFF_MODE 3'h2
`define ACS_OFF_TIMING 3'h3
`define ACS_OFF_DATA0 3'h4
`define ACS_OFF_DATA1 3'h5
`define ACS_OFF_DATA2 3'h6
`define ACS_OFF_DATA3 3'h7
`define ACS_DATA_SEL 2

// converter_status fields
`define ACS_ST_EOC 0
`define ACS_ST_BUSY 1
`define ACS_ST_OVF 2
`define ACS_ST_PTR_LO 4
`define ACS_ST_PTR_HI 5

// converter_control_one fields
`define ACS_C1_EN 0
`define ACS_C1_REF 1
`define ACS_C1_IRQEN 2
`define ACS_C1_W 3

// converter_mode_control fields
`define ACS_C2_CHAN_LO 0
`define ACS_C2_CHAN_HI 2
`define ACS_C2_REPEAT_SELECT 4
`define ACS_C2_SCAN 5
`define ACS_C2_START 7

// converter_timing_control fields
`define ACS_C3_CDIV_LO 0
`define ACS_C3_CDIV_HI 2
`define ACS_C3_DLY_LO 3
`define ACS_C3_DLY_HI 5
`define ACS_C3_W 6

// Reset values
`define ACS_RST_C1 3'h0
`define ACS_RST_C2 8'h00
`define ACS_RST_C3 6'h00
`define ACS_RST_PTR 2'h0

// Counts
`define ACS_PTR_RESTART 2'h3
`define ACS_LAST_CONV 2'h3
`define ACS_CDIV_MAX 3'h5

`endif

// >>> hdl/acs_timer.v
// Prescaler tick and sampling pause timer of the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
`include "acs_regs.vh"

module acs_timer (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire en,
  input wire [2:0] cdiv,
  input wire [2:0] delay,
  input wire restart,
  output wire tick,
  output wire pause_done
);

  reg [5:0] div_q;
  reg [2:0] pcnt_q;
  wire [2:0] cd;
  wire [5:0] lim;

  // Reserved divider codes behave as the slowest legal ratio
  assign cd = (cdiv > `ACS_CDIV_MAX) ? `ACS_CDIV_MAX : cdiv;
  assign lim = (6'h01 << cd) - 6'h01;
  assign tick = en & (div_q == lim);
  assign pause_done = (pcnt_q == delay);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 6'h00;
    end else if (ce) begin
      if (!en || tick) begin
        div_q <= 6'h00;
      end else begin
        div_q <= div_q + 6'h01;
      end
    end
  end

  // Pause length counts converter clock ticks
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pcnt_q <= 3'h0;
    end else if (ce) begin
      if (restart || !en) begin
        pcnt_q <= 3'h0;
      end else if (tick && !pause_done) begin
        pcnt_q <= pcnt_q + 3'h1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> hdl/acs_sequencer.v
// Conversion sequencer: modes, result registers, status flags and register port
`timescale 1ns/10ps
`default_nettype none
`include "acs_regs.vh"

// What this block does
// - One-shot single channel: data0, clear start, done
// - Continuous single channel: pause, start kept set
// - Continuous results rotate through four data registers
// - Done flag after all four registers filled
// - Status bits 5:4 name last written register
// - Start cleared: finish conversion, done, stop
// - Scan converts four channels, incrementing mux
// - Sampling pause before each next scan channel
// - Scan results go to data 0 to 3
// - One-shot scan end: clear start, done, interrupt
// - Continuous scan repeats while start stays set
// - Start cleared: finish whole burst, then done
// - Status: done bit0, busy bit1, overrun bit2
// - Software writes to done flag ignored
// - Reading any data register clears done flag
// - Four control/status plus four data registers mapped
// - Scan channel number wraps modulo eight
// - Interrupt drops when any data register read
// - Start rising edge loads last index 11
// - Unread overwrite sets overrun, write-1 clears
module acs_sequencer #(
  parameter RES_W = 10,
  parameter DW = 16
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire [2:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output wire [DW-1:0] reg_rdata,
  output wire adc_enable,
  output wire ref_enable,
  output wire conv_clk_en,
  output wire conv_start,
  output wire [2:0] conv_chan,
  input wire conv_done,
  input wire [RES_W-1:0] conv_result,
  output wire irq
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_PAUSE = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  reg [`ACS_C1_W-1:0] c1_q;
  reg [7:0] c2_q;
  reg [`ACS_C3_W-1:0] c3_q;
  reg eoc_q;
  reg ovf_q;
  reg [1:0] ptr_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [2:0] chan_q;
  reg [2:0] chan_d;
  reg [1:0] nconv_q;
  reg [1:0] nconv_d;
  reg eoc_set;
  reg start_clr;
  reg go_pause;
  reg conv_go;
  reg conv_start_q;
  reg [DW-1:0] rdata_q;
  reg [DW-1:0] rdata_d;
  wire [RES_W-1:0] data_w [0:3];
  wire [3:0] full_w;

  wire en;
  wire irq_en;
  wire start;
  wire scan;
  wire repeat_select;
  wire [2:0] chan_sel;
  wire wr_st;
  wire wr_c1;
  wire wr_c2;
  wire wr_c3;
  wire rd_any;
  wire rd_data;
  wire done_evt;
  wire [1:0] wr_idx;
  wire ovf_set;
  wire start_rise;
  wire busy;
  wire pause_done;
  wire [7:0] status_byte;
  wire [7:0] c2_wr_val;

  assign en = c1_q[`ACS_C1_EN];
  assign irq_en = c1_q[`ACS_C1_IRQEN];
  assign start = c2_q[`ACS_C2_START];
  assign scan = c2_q[`ACS_C2_SCAN];
  assign repeat_select = c2_q[`ACS_C2_REPEAT_SELECT];
  assign chan_sel = c2_q[`ACS_C2_CHAN_HI:`ACS_C2_CHAN_LO];

  // Register port decode; all side effects are frozen with the clock enable
  assign wr_st = ce & reg_wr & (reg_addr == `ACS_OFF_STATUS);
  assign wr_c1 = ce & reg_wr & (reg_addr == `ACS_OFF_CTL1);
  assign wr_c2 = ce & reg_wr & (reg_addr == `ACS_OFF_MODE);
  assign wr_c3 = ce & reg_wr & (reg_addr == `ACS_OFF_TIMING);
  assign rd_any = ce & reg_rd;
  assign rd_data = rd_any & reg_addr[`ACS_DATA_SEL];

  assign busy = (state_q != ST_IDLE);
  assign done_evt = ce & en & (state_q == ST_CONV) & conv_done;
  assign wr_idx = ptr_q + 2'h1;
  assign ovf_set = done_evt & full_w[wr_idx];

  // Reserved mode bits store zero; start cannot be set while disabled
  assign c2_wr_val = {reg_wdata[`ACS_C2_START] & en, 1'b0,
                      reg_wdata[`ACS_C2_SCAN], reg_wdata[`ACS_C2_REPEAT_SELECT], 1'b0,
                      reg_wdata[`ACS_C2_CHAN_HI:`ACS_C2_CHAN_LO]};
  assign start_rise = wr_c2 & c2_wr_val[`ACS_C2_START] & ~start;

  assign status_byte = {2'b00, ptr_q, 1'b0, ovf_q, busy, eoc_q};

  assign adc_enable = en;
  assign ref_enable = en & c1_q[`ACS_C1_REF];
  assign conv_start = conv_start_q;
  assign conv_chan = chan_q;
  assign reg_rdata = rdata_q;
  // Level request; it follows the done flag so a data read drops it
  assign irq = eoc_q & irq_en;

  acs_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .en(en),
    .cdiv(c3_q[`ACS_C3_CDIV_HI:`ACS_C3_CDIV_LO]),
    .delay(c3_q[`ACS_C3_DLY_HI:`ACS_C3_DLY_LO]),
    .restart(go_pause),
    .tick(conv_clk_en),
    .pause_done(pause_done)
  );

  // Sequencing state machine
  always @* begin
    state_d = state_q;
    chan_d = chan_q;
    nconv_d = nconv_q;
    eoc_set = 1'b0;
    start_clr = 1'b0;
    go_pause = 1'b0;
    conv_go = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (en && start) begin
          state_d = ST_PAUSE;
          chan_d = chan_sel;
          nconv_d = 2'h0;
          go_pause = 1'b1;
        end
      end
      ST_PAUSE: begin
        if (!start && !scan) begin
          // Nothing is converting during the pause, so stop at once
          state_d = ST_IDLE;
          eoc_set = 1'b1;
        end else if (pause_done) begin
          state_d = ST_CONV;
          conv_go = 1'b1;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          nconv_d = nconv_q + 2'h1;
          if (!scan) begin
            if (!repeat_select) begin
              eoc_set = 1'b1;
              start_clr = 1'b1;
              state_d = ST_IDLE;
            end else begin
              if (wr_idx == `ACS_PTR_RESTART) begin
                eoc_set = 1'b1;
              end
              if (start) begin
                state_d = ST_PAUSE;
                go_pause = 1'b1;
              end else begin
                eoc_set = 1'b1;
                state_d = ST_IDLE;
              end
            end
          end else if (nconv_q != `ACS_LAST_CONV) begin
            // Three bit add wraps channel seven to zero
            chan_d = chan_q + 3'h1;
            state_d = ST_PAUSE;
            go_pause = 1'b1;
          end else begin
            eoc_set = 1'b1;
            if (!repeat_select) begin
              start_clr = 1'b1;
              state_d = ST_IDLE;
            end else if (start) begin
              chan_d = chan_sel;
              nconv_d = 2'h0;
              state_d = ST_PAUSE;
              go_pause = 1'b1;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      chan_q <= 3'h0;
      nconv_q <= 2'h0;
      conv_start_q <= 1'b0;
    end else if (ce) begin
      if (!en) begin
        // Disabling terminates any conversion in flight
        state_q <= ST_IDLE;
        conv_start_q <= 1'b0;
      end else begin
        state_q <= state_d;
        chan_q <= chan_d;
        nconv_q <= nconv_d;
        conv_start_q <= conv_go;
      end
    end
  end

  // Control registers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      c1_q <= `ACS_RST_C1;
      c3_q <= `ACS_RST_C3;
    end else begin
      if (wr_c1) begin
        c1_q <= reg_wdata[`ACS_C1_W-1:0];
      end
      if (wr_c3) begin
        c3_q <= reg_wdata[`ACS_C3_W-1:0];
      end
    end
  end

  // Hardware clear of start wins over a software write in the same cycle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      c2_q <= `ACS_RST_C2;
    end else if (ce) begin
      if (!en) begin
        c2_q[`ACS_C2_START] <= 1'b0;
      end else if (start_clr) begin
        c2_q[`ACS_C2_START] <= 1'b0;
      end else if (wr_c2) begin
        c2_q[`ACS_C2_START] <= c2_wr_val[`ACS_C2_START];
      end
      if (wr_c2) begin
        c2_q[6:0] <= c2_wr_val[6:0];
      end
    end
  end

  // Status flags; the status write only reaches the overrun bit
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eoc_q <= 1'b0;
      ovf_q <= 1'b0;
      ptr_q <= `ACS_RST_PTR;
    end else if (ce) begin
      if (!en) begin
        eoc_q <= 1'b0;
        ovf_q <= 1'b0;
      end else begin
        eoc_q <= eoc_set | (eoc_q & ~rd_data);
        ovf_q <= ovf_set | (ovf_q & ~(wr_st & reg_wdata[`ACS_ST_OVF]));
      end
      if (start_rise) begin
        ptr_q <= `ACS_PTR_RESTART;
      end else if (done_evt) begin
        ptr_q <= wr_idx;
      end
    end
  end

  // Result registers with their unread markers, one per entry
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_res
      localparam [31:0] ENTRY = gi;
      localparam [1:0] IDX = ENTRY[1:0];
      wire hit_wr;
      wire hit_rd;
      reg [RES_W-1:0] val_q;
      reg full_q;
      assign hit_wr = done_evt & (wr_idx == IDX);
      assign hit_rd = rd_data & (reg_addr[1:0] == IDX);
      // Each entry owns its flops so no vector has two driving processes
      assign data_w[gi] = val_q;
      assign full_w[gi] = full_q;
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          val_q <= {RES_W{1'b0}};
          full_q <= 1'b0;
        end else if (ce) begin
          if (hit_wr) begin
            val_q <= conv_result;
          end
          if (!en) begin
            full_q <= 1'b0;
          end else begin
            full_q <= hit_wr | (full_q & ~hit_rd);
          end
        end
      end
    end
  endgenerate

  // Read data is registered; the answer stands until the next read
  always @* begin
    rdata_d = {DW{1'b0}};
    case (reg_addr)
      `ACS_OFF_STATUS: rdata_d = {{(DW-8){1'b0}}, status_byte};
      `ACS_OFF_CTL1: rdata_d = {{(DW-`ACS_C1_W){1'b0}}, c1_q};
      `ACS_OFF_MODE: rdata_d = {{(DW-8){1'b0}}, c2_q};
      `ACS_OFF_TIMING: rdata_d = {{(DW-`ACS_C3_W){1'b0}}, c3_q};
      default: rdata_d = {{(DW-RES_W){1'b0}}, data_w[reg_addr[1:0]]};
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= {DW{1'b0}};
    end else if (rd_any) begin
      rdata_q <= rdata_d;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/acs_sequencer_asserts.sv
// Port checker of the conversion sequencer, bound to the design
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer_checker #(
  parameter RES_W = 10,
  parameter DW = 16
) (
  input wire mclk,
  input wire rst_n,
  input wire ce,
  input wire [2:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [DW-1:0] reg_rdata,
  input wire adc_enable,
  input wire ref_enable,
  input wire conv_clk_en,
  input wire conv_start,
  input wire [2:0] conv_chan,
  input wire conv_done,
  input wire [RES_W-1:0] conv_result,
  input wire irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Completion is excluded since a same-cycle set wins over the read clear
  sequence s_data_rd;
    ce && reg_rd && reg_addr[2] && !conv_done;
  endsequence
  sequence s_stat_rd;
    ce && reg_rd && reg_addr == 3'h0 && !conv_done;
  endsequence
  AST_IRQ_DROP: assert property (s_data_rd |=> !irq) else $error("irq still high after data read");
  AST_IRQ_CAUSE: assert property ($rose(irq) && !$past(reg_wr) |-> $past(conv_done))
    else $error("irq rose without a finished conversion");
  AST_IRQ_ENABLE: assert property (irq |-> adc_enable) else $error("irq while disabled");
  AST_START_PULSE: assert property (conv_start |=> !conv_start) else $error("start pulse too long");
  AST_NO_CONV_OFF: assert property (!adc_enable && $past(adc_enable) == 1'b0 |-> !conv_start && !conv_clk_en)
    else $error("converter active while disabled");
  AST_RDATA_HOLD: assert property (!(ce && reg_rd) |=> $stable(reg_rdata)) else $error("read data moved");
  AST_STATUS_RSV: assert property (s_stat_rd |=> reg_rdata[DW-1:6] == 0 && !reg_rdata[3])
    else $error("reserved status bits set");
  AST_DATA_ZEXT: assert property (s_data_rd |=> reg_rdata[DW-1:RES_W] == 0) else $error("result not zero extended");
  AST_DONE_CLEAR: assert property (s_data_rd ##1 !conv_done ##1 s_stat_rd |=> !reg_rdata[0])
    else $error("done flag survived data read");
endmodule

bind acs_sequencer acs_sequencer_checker #(.RES_W(RES_W), .DW(DW)) u_chk (.mclk(mclk), .rst_n(rst_n), .ce(ce),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .adc_enable(adc_enable), .ref_enable(ref_enable), .conv_clk_en(conv_clk_en), .conv_start(conv_start),
  .conv_chan(conv_chan), .conv_done(conv_done), .conv_result(conv_result), .irq(irq));
`default_nettype wire

// >>> testbench/tb_acs_sequencer.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_acs_sequencer;
  logic mclk = 0, rst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0, conv_done = 0, pend = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [9:0] conv_result = 10'h000;
  logic [31:0] rnd = 32'he578_3b53;
  logic [16:0] q[$];
  logic [15:0] rq[$], chq[$];
  int failures = 0, cmp_count = 0, cyc = 0, ticks = 0;
  wire [15:0] reg_rdata;
  wire conv_start, irq, adc_enable, ref_enable, conv_clk_en;
  wire [2:0] conv_chan;
  always #2.5 mclk = ~mclk;
  acs_sequencer DUT (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_enable(adc_enable), .ref_enable(ref_enable),
    .conv_clk_en(conv_clk_en),
    .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done), .conv_result(conv_result), .irq(irq));
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input [15:0] g, input [15:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input [2:0] a, input [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge mclk);
    reg_wr = 0;
    @(negedge mclk);
  endtask
  // A note is queued per read; polling reads queue a skip note to keep order
  task automatic rd(input [2:0] a, input [15:0] e, input bit s);
    reg_addr = a;
    reg_rd = 1;
    q.push_back({s, e});
    @(negedge mclk);
    reg_rd = 0;
    @(negedge mclk);
  endtask
  always @(posedge mclk) pend <= reg_rd & ce;
  always @(negedge mclk) begin
    if (pend) begin
      if (!q[0][16]) chk(reg_rdata, q[0][15:0]);
      void'(q.pop_front());
    end
  end
  // Far converter: answers each start pulse two cycles later with a random result
  initial forever begin
    @(negedge mclk);
    if (conv_start === 1'b1) begin
      chq.push_back({13'h0, conv_chan});
      @(negedge mclk);
      @(negedge mclk);
      rnd = lfsr(rnd);
      conv_result = rnd[9:0];
      rq.push_back({6'h0, rnd[9:0]});
      conv_done = 1;
      @(negedge mclk);
      conv_done = 0;
    end
  end
  task automatic run(input [7:0] m);
    int n, t, k;
    logic [7:0] st;
    rq.delete();
    chq.delete();
    wr(3'h2, m | 8'h80);
    for (t = 0; t < 300 && irq !== 1'b1; t++) @(negedge mclk);
    chk({15'h0, irq}, 16'h1);
    rd(3'h2, {8'h0, m[4], m[6:0]}, 0);
    wr(3'h2, m);
    rd(3'h0, 16'h0, 1);
    for (t = 0; t < 100 && reg_rdata[1] !== 1'b0; t++) rd(3'h0, 16'h0, 1);
    n = rq.size();
    st = {2'h0, n[1:0] - 2'h1, 1'b0, n > 4, 2'h1};
    chk(16'(m[4] ? (m[5] ? n % 4 : n >= 4) : n), m[4] ? {15'h0, !m[5]} : (m[5] ? 16'h4 : 16'h1));
    rd(3'h0, {8'h0, st}, 0);
    for (k = 0; k < n && k < 4; k++) rd(3'(4 + k), rq[k + 4 * ((n - 1 - k) / 4)], 0);
    rd(3'h0, {8'h0, st & 8'hfe}, 0);
    chk({15'h0, irq}, 16'h0);
    wr(3'h0, 8'h05);
    rd(3'h0, {8'h0, st & 8'hf0}, 0);
    for (k = 0; k < chq.size(); k++) chk(chq[k], {13'h0, 3'(m[2:0] + (m[5] ? k % 4 : 0))});
    $display("Mode %h test done at %0t", m, $time);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1;
    for (int a = 0; a < 4; a++) rd(3'(a), 16'h0, 0);
    chk({13'h0, adc_enable, ref_enable, conv_clk_en}, 16'h0);
    wr(3'h1, 8'h07);
    rd(3'h1, 16'h0007, 0);
    wr(3'h3, 8'h00);
    chk({13'h0, adc_enable, ref_enable, conv_clk_en}, 16'h7);
    $display("Register test done");
    run(8'h03);
    run(8'h26);
    run(8'h17);
    wr(3'h3, 8'h0a);
    rd(3'h3, 16'h000a, 0);
    repeat (8) @(negedge mclk) ticks += conv_clk_en;
    chk(16'(ticks), 16'h2);
    run(8'h35);
    test_done();
  end
endmodule
`default_nettype wire
